/* File: wg_map.svh */
// Register offsets, reset values and timing figures of the waveform generators.
`ifndef WG_MAP_SVH
`define WG_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets (index of a 16-bit register on the plain register port)
// ----------------------------------------------------------------------------
`define WG_ADDR_W 3
`define WG_DATA_W 16
`define WG_OFS_SYM_HALF 3'h0
`define WG_OFS_PLS_HIGH 3'h1
`define WG_OFS_PLS_LOW 3'h2
`define WG_OFS_RND_HIGH 3'h3
`define WG_OFS_RND_LOW 3'h4
`define WG_OFS_STATUS 3'h5

// ----------------------------------------------------------------------------
// Reset values of the span registers, in timebase ticks
// ----------------------------------------------------------------------------
`define WG_SPAN_RST 16'h0064
`define WG_ZERO16 16'h0000
`define WG_ONE16 16'h0001

// ----------------------------------------------------------------------------
// Status register field positions
// ----------------------------------------------------------------------------
`define WG_ST_SYM_OUT 0
`define WG_ST_PLS_OUT 1
`define WG_ST_RND_OUT 2
`define WG_ST_RND_LO 3
`define WG_ST_RND_HI 4
`define WG_ST_SYM_EN 5
`define WG_ST_PLS_EN 6
`define WG_ST_RND_EN 7

// ----------------------------------------------------------------------------
// Timebase: one tick every 10 ms at a 50 ns clock
// ----------------------------------------------------------------------------
`define WG_CLK_PERIOD_NS 50
`define WG_TICK_NS 10000000
`define WG_TICK_CYC (`WG_TICK_NS / `WG_CLK_PERIOD_NS)
`define WG_TICK_W 18
`define WG_TICK_ZERO 18'h00000
`define WG_TICK_ONE 18'h00001

// ----------------------------------------------------------------------------
// Pseudo-random source
// ----------------------------------------------------------------------------
`define WG_LFSR_SEED 16'hace1
`define WG_LFSR_TAPS 16'hb400

`endif

/* File: wg_pkg.sv */
// Types shared by the waveform generator design files.
`default_nettype none
package wg_pkg;

  typedef enum logic [1:0]
  {
    WG_RND_IDLE = 2'b00,
    WG_RND_ON_WAIT = 2'b01,
    WG_RND_OFF_WAIT = 2'b10
  } wg_rnd_state_t;

endpackage
`default_nettype wire

/* File: wg_lfsr.sv */
// Free-running 16-bit pseudo-random source with a registered output.
`timescale 1ns/1ps
`default_nettype none
`include "wg_map.svh"

module wg_lfsr
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Random word
  output logic [15:0] rnd_o
);

  logic [15:0] lfsr_r;
  logic [15:0] lfsr_nxt;

  always_comb
  begin
    if (lfsr_r[0])
    begin
      lfsr_nxt = (lfsr_r >> 1) ^ `WG_LFSR_TAPS;
    end
    else
    begin
      lfsr_nxt = lfsr_r >> 1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      lfsr_r <= `WG_LFSR_SEED;
    end
    else
    begin
      lfsr_r <= lfsr_nxt;
    end
  end

  assign rnd_o = lfsr_r;

endmodule
`default_nettype wire

/* File: wg_top.sv */
// Symmetric clock, asynchronous pulse and random generators on one timebase.
//
// Summary of operation
// - Symmetric clock runs only while enabled.
// - Symmetric output alternates, each level half_period.
// - Symmetric clock stops when enable drops.
// - Pulse generator active only while enabled.
// - Pulse output high_span high, low_span low.
// - Invert input acts only while pulse enabled.
// - Enable rise starts random on delay.
// - On delay expiry sets output if enabled.
// - Enable fall aborts on delay, output unchanged.
// - Enable fall starts random off delay.
// - Off delay expiry clears output if disabled.
// - Enable rise aborts off delay, output unchanged.
// - Delay timers restart from zero after power-up.
`timescale 1ns/1ps
`default_nettype none
`include "wg_map.svh"

module wg_top
#(
  parameter int unsigned TICK_CYC = `WG_TICK_CYC
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Register port
  input wire logic [`WG_ADDR_W-1:0] reg_addr_i,
  input wire logic [`WG_DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [`WG_DATA_W-1:0] reg_rdata_o,
  // Symmetric clock generator
  input wire logic sym_en_i,
  output logic sym_out_o,
  // Asynchronous pulse generator
  input wire logic pls_en_i,
  input wire logic pls_inv_i,
  output logic pls_out_o,
  // Random generator
  input wire logic rnd_en_i,
  output logic rnd_out_o
);

  // --------------------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------------------

  // True when one more tick completes a span; a span of zero acts as one tick.
  function automatic logic span_done(input logic [15:0] cnt, input logic [15:0] lim);
    logic [16:0] next_cnt;
    next_cnt = {1'b0, cnt} + 17'h00001;
    return next_cnt >= {1'b0, lim};
  endfunction

  // Scales a random word into 0..span inclusive.
  function automatic logic [15:0] scale_rnd(input logic [15:0] rnd, input logic [15:0] span);
    logic [32:0] prod;
    prod = {17'h00000, rnd} * ({17'h00000, span} + 33'h000000001);
    return prod[31:16];
  endfunction

  // --------------------------------------------------------------------------
  // Configuration registers and register port
  // --------------------------------------------------------------------------

  logic [15:0] sym_half_r, sym_half_nxt;
  logic [15:0] pls_high_r, pls_high_nxt;
  logic [15:0] pls_low_r, pls_low_nxt;
  logic [15:0] rnd_high_r, rnd_high_nxt;
  logic [15:0] rnd_low_r, rnd_low_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic [15:0] status;

  logic sym_out_r;
  logic pls_out_r;
  logic rnd_out_r;
  wg_pkg::wg_rnd_state_t rnd_st_r;

  always_comb
  begin
    status = `WG_ZERO16;
    status[`WG_ST_SYM_OUT] = sym_out_r;
    status[`WG_ST_PLS_OUT] = pls_out_r;
    status[`WG_ST_RND_OUT] = rnd_out_r;
    status[`WG_ST_RND_LO] = rnd_st_r[0];
    status[`WG_ST_RND_HI] = rnd_st_r[1];
    status[`WG_ST_SYM_EN] = sym_en_i;
    status[`WG_ST_PLS_EN] = pls_en_i;
    status[`WG_ST_RND_EN] = rnd_en_i;
  end

  always_comb
  begin
    sym_half_nxt = sym_half_r;
    pls_high_nxt = pls_high_r;
    pls_low_nxt = pls_low_r;
    rnd_high_nxt = rnd_high_r;
    rnd_low_nxt = rnd_low_r;
    rdata_nxt = `WG_ZERO16;
    if (reg_wr_i)
    begin
      if (reg_addr_i == `WG_OFS_SYM_HALF)
      begin
        sym_half_nxt = reg_wdata_i;
      end
      else if (reg_addr_i == `WG_OFS_PLS_HIGH)
      begin
        pls_high_nxt = reg_wdata_i;
      end
      else if (reg_addr_i == `WG_OFS_PLS_LOW)
      begin
        pls_low_nxt = reg_wdata_i;
      end
      else if (reg_addr_i == `WG_OFS_RND_HIGH)
      begin
        rnd_high_nxt = reg_wdata_i;
      end
      else if (reg_addr_i == `WG_OFS_RND_LOW)
      begin
        rnd_low_nxt = reg_wdata_i;
      end
    end
    if (reg_rd_i)
    begin
      if (reg_addr_i == `WG_OFS_SYM_HALF)
      begin
        rdata_nxt = sym_half_r;
      end
      else if (reg_addr_i == `WG_OFS_PLS_HIGH)
      begin
        rdata_nxt = pls_high_r;
      end
      else if (reg_addr_i == `WG_OFS_PLS_LOW)
      begin
        rdata_nxt = pls_low_r;
      end
      else if (reg_addr_i == `WG_OFS_RND_HIGH)
      begin
        rdata_nxt = rnd_high_r;
      end
      else if (reg_addr_i == `WG_OFS_RND_LOW)
      begin
        rdata_nxt = rnd_low_r;
      end
      else if (reg_addr_i == `WG_OFS_STATUS)
      begin
        rdata_nxt = status;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sym_half_r <= `WG_SPAN_RST;
      pls_high_r <= `WG_SPAN_RST;
      pls_low_r <= `WG_SPAN_RST;
      rnd_high_r <= `WG_SPAN_RST;
      rnd_low_r <= `WG_SPAN_RST;
      rdata_r <= `WG_ZERO16;
    end
    else
    begin
      sym_half_r <= sym_half_nxt;
      pls_high_r <= pls_high_nxt;
      pls_low_r <= pls_low_nxt;
      rnd_high_r <= rnd_high_nxt;
      rnd_low_r <= rnd_low_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Shared timebase
  // --------------------------------------------------------------------------

  logic [`WG_TICK_W-1:0] tick_cnt_r, tick_cnt_nxt;
  logic tick;

  assign tick = (tick_cnt_r == `WG_TICK_W'(TICK_CYC - 1));

  always_comb
  begin
    if (tick)
    begin
      tick_cnt_nxt = `WG_TICK_ZERO;
    end
    else
    begin
      tick_cnt_nxt = tick_cnt_r + `WG_TICK_ONE;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tick_cnt_r <= `WG_TICK_ZERO;
    end
    else
    begin
      tick_cnt_r <= tick_cnt_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Symmetric clock generator
  // --------------------------------------------------------------------------

  logic [15:0] sym_cnt_r, sym_cnt_nxt;
  logic sym_out_nxt;

  always_comb
  begin
    sym_cnt_nxt = sym_cnt_r;
    sym_out_nxt = sym_out_r;
    if (!sym_en_i)
    begin
      sym_cnt_nxt = `WG_ZERO16;
      sym_out_nxt = 1'b0;
    end
    else if (tick)
    begin
      if (span_done(sym_cnt_r, sym_half_r))
      begin
        sym_cnt_nxt = `WG_ZERO16;
        sym_out_nxt = ~sym_out_r;
      end
      else
      begin
        sym_cnt_nxt = sym_cnt_r + `WG_ONE16;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sym_cnt_r <= `WG_ZERO16;
      sym_out_r <= 1'b0;
    end
    else
    begin
      sym_cnt_r <= sym_cnt_nxt;
      sym_out_r <= sym_out_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Asynchronous pulse generator
  // --------------------------------------------------------------------------

  logic [15:0] pls_cnt_r, pls_cnt_nxt;
  logic pls_phase_r, pls_phase_nxt;
  logic pls_out_nxt;

  always_comb
  begin
    pls_cnt_nxt = pls_cnt_r;
    pls_phase_nxt = pls_phase_r;
    if (!pls_en_i)
    begin
      pls_cnt_nxt = `WG_ZERO16;
      pls_phase_nxt = 1'b1;
    end
    else if (tick)
    begin
      if (span_done(pls_cnt_r, pls_phase_r ? pls_high_r : pls_low_r))
      begin
        pls_cnt_nxt = `WG_ZERO16;
        pls_phase_nxt = ~pls_phase_r;
      end
      else
      begin
        pls_cnt_nxt = pls_cnt_r + `WG_ONE16;
      end
    end
    // The invert input only matters while the generator runs.
    pls_out_nxt = pls_en_i & (pls_phase_nxt ^ pls_inv_i);
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pls_cnt_r <= `WG_ZERO16;
      pls_phase_r <= 1'b1;
      pls_out_r <= 1'b0;
    end
    else
    begin
      pls_cnt_r <= pls_cnt_nxt;
      pls_phase_r <= pls_phase_nxt;
      pls_out_r <= pls_out_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Random generator
  // --------------------------------------------------------------------------

  logic [15:0] rnd_word;
  logic rnd_en_q_r;
  logic rnd_rise;
  logic rnd_fall;
  logic [15:0] rnd_cnt_r, rnd_cnt_nxt;
  logic [15:0] rnd_dly_r, rnd_dly_nxt;
  logic rnd_out_nxt;
  wg_pkg::wg_rnd_state_t rnd_st_nxt;

  wg_lfsr u_lfsr
  (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .rnd_o(rnd_word)
  );

  assign rnd_rise = rnd_en_i & ~rnd_en_q_r;
  assign rnd_fall = ~rnd_en_i & rnd_en_q_r;

  always_comb
  begin
    rnd_st_nxt = rnd_st_r;
    rnd_cnt_nxt = rnd_cnt_r;
    rnd_dly_nxt = rnd_dly_r;
    rnd_out_nxt = rnd_out_r;
    if (rnd_rise)
    begin
      // A rise also abandons a pending off delay without touching the output.
      rnd_st_nxt = wg_pkg::WG_RND_ON_WAIT;
      rnd_cnt_nxt = `WG_ZERO16;
      rnd_dly_nxt = scale_rnd(rnd_word, rnd_high_r);
    end
    else if (rnd_fall)
    begin
      // A fall also abandons a pending on delay without touching the output.
      rnd_st_nxt = wg_pkg::WG_RND_OFF_WAIT;
      rnd_cnt_nxt = `WG_ZERO16;
      rnd_dly_nxt = scale_rnd(rnd_word, rnd_low_r);
    end
    else
    begin
      case (rnd_st_r)
        wg_pkg::WG_RND_ON_WAIT:
        begin
          if (rnd_cnt_r >= rnd_dly_r)
          begin
            rnd_out_nxt = 1'b1;
            rnd_st_nxt = wg_pkg::WG_RND_IDLE;
            rnd_cnt_nxt = `WG_ZERO16;
          end
          else if (tick)
          begin
            rnd_cnt_nxt = rnd_cnt_r + `WG_ONE16;
          end
        end
        wg_pkg::WG_RND_OFF_WAIT:
        begin
          if (rnd_cnt_r >= rnd_dly_r)
          begin
            rnd_out_nxt = 1'b0;
            rnd_st_nxt = wg_pkg::WG_RND_IDLE;
            rnd_cnt_nxt = `WG_ZERO16;
          end
          else if (tick)
          begin
            rnd_cnt_nxt = rnd_cnt_r + `WG_ONE16;
          end
        end
        default:
        begin
          rnd_st_nxt = wg_pkg::WG_RND_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rnd_st_r <= wg_pkg::WG_RND_IDLE;
      rnd_cnt_r <= `WG_ZERO16;
      rnd_dly_r <= `WG_ZERO16;
      rnd_out_r <= 1'b0;
      rnd_en_q_r <= 1'b0;
    end
    else
    begin
      rnd_st_r <= rnd_st_nxt;
      rnd_cnt_r <= rnd_cnt_nxt;
      rnd_dly_r <= rnd_dly_nxt;
      rnd_out_r <= rnd_out_nxt;
      rnd_en_q_r <= rnd_en_i;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------

  assign reg_rdata_o = rdata_r;
  assign sym_out_o = sym_out_r;
  assign pls_out_o = pls_out_r;
  assign rnd_out_o = rnd_out_r;

endmodule
`default_nettype wire

/* File: wg_assertions.sv */
// Port checks of the waveform generators.
`timescale 1ns/1ps
`default_nettype none
`include "wg_map.svh"
module wg_assertions
#(
  parameter int unsigned TICK_CYC = 4
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Register port
  input wire logic [`WG_ADDR_W-1:0] reg_addr_i,
  input wire logic [`WG_DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [`WG_DATA_W-1:0] reg_rdata_o,
  // Generator enables and outputs
  input wire logic sym_en_i,
  input wire logic sym_out_o,
  input wire logic pls_en_i,
  input wire logic pls_inv_i,
  input wire logic pls_out_o,
  input wire logic rnd_en_i,
  input wire logic rnd_out_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [15:0] half_r, rhi_r, rlo_r;
  logic sym_q_r, en_q_r, run_r, tg;
  int cyc_r, on_r, off_r, sym_len, on_lim, off_lim;
  assign tg = (sym_out_o != sym_q_r) && en_q_r;
  assign sym_len = ((half_r == 16'h0) ? 1 : int'(half_r)) * TICK_CYC;
  assign on_lim = (int'(rhi_r) + 1) * TICK_CYC + 4;
  assign off_lim = (int'(rlo_r) + 1) * TICK_CYC + 4;
  // Shadows the symmetric and random span registers and times levels and enable runs.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      half_r <= `WG_SPAN_RST;
      rhi_r <= `WG_SPAN_RST;
      rlo_r <= `WG_SPAN_RST;
      {sym_q_r, en_q_r, run_r} <= 3'h0;
      cyc_r <= 0;
      on_r <= 0;
      off_r <= 0;
    end
    else
    begin
      if (reg_wr_i && reg_addr_i == `WG_OFS_SYM_HALF) half_r <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == `WG_OFS_RND_HIGH) rhi_r <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == `WG_OFS_RND_LOW) rlo_r <= reg_wdata_i;
      sym_q_r <= sym_out_o;
      en_q_r <= sym_en_i;
      run_r <= sym_en_i && (tg || run_r);
      cyc_r <= tg ? 1 : cyc_r + 1;
      on_r <= rnd_en_i ? ((on_r < 2000) ? on_r + 1 : on_r) : 0;
      off_r <= !rnd_en_i ? ((off_r < 2000) ? off_r + 1 : off_r) : 0;
    end
  end
  sequence s_on_late;
    rnd_en_i && on_r > on_lim;
  endsequence
  sequence s_off_late;
    !rnd_en_i && off_r > off_lim;
  endsequence
  a_sym_stop: assert property (!sym_en_i |=> !sym_out_o)
    else $error("symmetric output high while disabled");
  a_sym_half: assert property (tg && run_r |-> cyc_r == sym_len)
    else $error("symmetric level length wrong");
  a_pls_stop: assert property (!pls_en_i |=> !pls_out_o)
    else $error("pulse output high while disabled");
  a_rd_idle: assert property (!reg_rd_i |=> reg_rdata_o == `WG_ZERO16)
    else $error("read data outside read cycle");
  a_rnd_set_en: assert property ($rose(rnd_out_o) |-> $past(rnd_en_i, 2))
    else $error("random output set without enable");
  a_rnd_clr_dis: assert property ($fell(rnd_out_o) |-> !$past(rnd_en_i, 2))
    else $error("random output cleared while enabled");
  a_rnd_on_bound: assert property (s_on_late |-> rnd_out_o)
    else $error("random on delay too long");
  a_rnd_off_bound: assert property (s_off_late |-> !rnd_out_o)
    else $error("random off delay too long");
endmodule
`default_nettype wire

/* File: wg_en_src.sv */
// Model of the logic that drives the generator enables.
`timescale 1ns/1ps
`default_nettype none
module wg_en_src
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Requested levels: sym, pls, inv, rnd
  input wire logic [3:0] req_i,
  // Enable lines
  output logic sym_en_o,
  output logic pls_en_o,
  output logic pls_inv_o,
  output logic rnd_en_o
);
  logic [3:0] lvl_r;
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      lvl_r <= 4'h0;
    else
      lvl_r <= req_i;
  end
  assign {sym_en_o, pls_en_o, pls_inv_o, rnd_en_o} = lvl_r;
endmodule
`default_nettype wire

/* File: tb.sv */
// Self-checking bench of the waveform generators.
`timescale 1ns/1ps
`default_nettype none
`include "wg_map.svh"
module tb;
  localparam int TICK = 4;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [2:0] reg_addr_i = 3'h0;
  logic [15:0] reg_wdata_i = 16'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [3:0] req = 4'h0;
  logic [15:0] reg_rdata_o;
  logic sym_en_i, pls_en_i, pls_inv_i, rnd_en_i, sym_out_o, pls_out_o, rnd_out_o;
  int n_fail = 0;
  int samples_checked = 0;
  always #25 clk_i = ~clk_i;
  wg_en_src wg_en_src_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req),
    .sym_en_o(sym_en_i), .pls_en_o(pls_en_i), .pls_inv_o(pls_inv_i), .rnd_en_o(rnd_en_i));
  wg_top #(.TICK_CYC(TICK)) wg_top_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .sym_en_i(sym_en_i),
    .sym_out_o(sym_out_o), .pls_en_i(pls_en_i), .pls_inv_i(pls_inv_i),
    .pls_out_o(pls_out_o), .rnd_en_i(rnd_en_i), .rnd_out_o(rnd_out_o));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk_i);
    {reg_addr_i, reg_wdata_i, reg_wr_i} <= {a, d, 1'b1};
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [15:0] e);
    @(posedge clk_i);
    {reg_addr_i, reg_rd_i} <= {a, 1'b1};
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    @(negedge clk_i);
    chk("reg", e, reg_rdata_o);
  endtask
  task automatic setreq(input logic [3:0] v);
    @(posedge clk_i);
    req <= v;
    repeat (3) @(negedge clk_i);
  endtask
  function automatic logic sig(input int w);
    return (w == 0) ? sym_out_o : ((w == 1) ? pls_out_o : rnd_out_o);
  endfunction
  task automatic waitv(input int w, input logic l, input int lim);
    int n;
    n = 0;
    while (sig(w) !== l && n < lim)
    begin
      @(negedge clk_i);
      n++;
    end
    chk("level", {15'h0, l}, {15'h0, sig(w)});
  endtask
  // Counts the cycles of the next full level l of output w.
  task automatic hold(input int w, input logic l, input int e);
    int n;
    n = 0;
    waitv(w, l, 300);
    while (sig(w) === l && n < 300)
    begin
      @(negedge clk_i);
      n++;
    end
    chk("hold", e[15:0], n[15:0]);
  endtask
  task automatic stop_test;
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    #(50 * 20000);
    n_fail++;
    stop_test();
  end
  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(negedge clk_i);
    chk("outs", 16'h0, {13'h0, sym_out_o, pls_out_o, rnd_out_o});
    for (int a = 0; a < 5; a++) rd(a[2:0], `WG_SPAN_RST);
    wr(3'h5, 16'hffff);
    rd(3'h5, 16'h0);
    rd(3'h6, 16'h0);
    for (int a = 0; a < 5; a++) wr(a[2:0], (a == 2) ? 16'h3 : 16'h2);
    rd(3'h2, 16'h3);
    setreq(4'h8);
    hold(0, 1'b1, 2 * TICK);
    hold(0, 1'b0, 2 * TICK);
    setreq(4'h0);
    chk("sym", 16'h0, {15'h0, sym_out_o});
    setreq(4'h4);
    hold(1, 1'b0, 3 * TICK);
    hold(1, 1'b1, 2 * TICK);
    setreq(4'h6);
    hold(1, !pls_out_o, pls_out_o ? 2 * TICK : 3 * TICK);
    setreq(4'h2);
    chk("pls", 16'h0, {15'h0, pls_out_o});
    setreq(4'h1);
    waitv(2, 1'b1, 3 * TICK + 4);
    setreq(4'h0);
    waitv(2, 1'b0, 3 * TICK + 4);
    wr(3'h3, 16'h0);
    setreq(4'h1);
    rd(3'h5, 16'h0084);
    setreq(4'h0);
    waitv(2, 1'b0, 3 * TICK + 4);
    // Full-scale spans give a delay equal to the nonzero random word, so waits stay pending.
    wr(3'h3, 16'hffff);
    wr(3'h4, 16'hffff);
    setreq(4'h1);
    rd(3'h5, 16'h0088);
    setreq(4'h0);
    rd(3'h5, 16'h0010);
    setreq(4'h1);
    rd(3'h5, 16'h0088);
    // A reset in the middle of a pending delay must leave every timer idle.
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    req <= 4'h0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(3'h5, 16'h0000);
    rd(3'h3, `WG_SPAN_RST);
    stop_test();
  end
endmodule
bind wg_top wg_assertions #(.TICK_CYC(TICK_CYC)) wg_assertions_i (.clk_i(clk_i),
  .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .sym_en_i(sym_en_i), .sym_out_o(sym_out_o), .pls_en_i(pls_en_i),
  .pls_inv_i(pls_inv_i), .pls_out_o(pls_out_o), .rnd_en_i(rnd_en_i),
  .rnd_out_o(rnd_out_o));
`default_nettype wire
